/* design/vof_pkg.sv */
/*
  constants, types and field layout for the video output format block.
  assumes: one clock domain, registers written by the serial control
  bus decoder through a simple byte write/read port.
*/
// Functional notes
// RULE_01 - vertical shuffle: even rows before odd rows
// RULE_02 - horizontal mirror: rightmost column delivered first
// RULE_03 - vertical flip: bottom row delivered first
// RULE_04 - readout bit 5 tri-states frame/line strobes; in eight-wire mode the code uses format bit 5 instead
// RULE_05 - readout bit 6 tri-states qualifying clock
// RULE_06 - register reads return written value immediately
// RULE_07 - readout bit 7 predivides input clock by 1.5
// RULE_08 - strobes driven only when pin and bit low
// RULE_09 - qualifying clock driven only when pin and bit low
// RULE_10 - format bits 1:0 pick 5, 4 or 8 wires
// RULE_11 - eight-wire mode: strobe pins carry data bits 5, 6
// RULE_12 - format bit 2 low inserts SAV/EAV codes
// RULE_13 - data bus enabled only when bit 5 and pin low
// RULE_14 - format bit 6 retimes tri-state bits to field
// RULE_15 - codes disabled also disables frame strobe
// RULE_16 - codes disabled: qualifying clock only if free-running
// RULE_17 - data bus driven after reset
// RULE_18 - qualifying clock mode code 01 means free-running
// RULE_19 - retimed update lands on first clock of field
package vof_pkg;

  // register indices on the serial control bus
  localparam logic [7:0] ADDR_READOUT = 8'h16;
  localparam logic [7:0] ADDR_OUTBUS = 8'h17;

  // reset values
  localparam logic [7:0] RST_READOUT = 8'h01;
  localparam logic [7:0] RST_OUTBUS = 8'h18;

  // readout_order_and_pin_enable fields
  localparam int RO_VSHUF = 2;
  localparam int RO_HMIRR = 3;
  localparam int RO_VFLIP = 4;
  localparam int RO_STRB_DIS = 5;
  localparam int RO_QCK_DIS = 6;
  localparam int RO_PREDIV = 7;

  // output_bus_format fields
  localparam int OB_WIDTH_HI = 1;
  localparam int OB_CODE_OFF = 2;
  localparam int OB_DATA_DIS = 5;
  localparam int OB_RETIME = 6;
  localparam logic [1:0] WIDTH_FIVE = 2'h0;

  // qualifying clock mode codes
  localparam logic [1:0] QCK_FREE = 2'h1;

  // predivider: two ticks in every three input clocks
  localparam logic [1:0] PREDIV_LAST = 2'h2;

  // embedded code bytes (arbitrary values)
  localparam logic [7:0] SAV_CODE = 8'hab;
  localparam logic [7:0] EAV_CODE = 8'hb6;

  // serialiser states, gray along idle->hi->lo
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_HI = 2'h1,
    SER_LO = 2'h3,
    SER_BYTE = 2'h2
  } vof_ser_t;

  // everything that goes to the output pads
  typedef struct packed {
    logic [7:0] data;
    logic data_oe;
    logic frame_strobe;
    logic frame_strobe_oe;
    logic line_strobe;
    logic line_strobe_oe;
    logic qualifying_clock;
    logic qualifying_clock_oe;
  } vof_pins_t;

endpackage

/* design/vof_video_output_format_ctrl.sv */
/*
  output format and output enable control of the sensor video port:
  readout address mapping, clock predivider, bus width serialiser,
  embedded code insertion and pad enables.
  assumes: the video timing generator, clock generator and pixel
  source run on clk_sys_in; only the output-enable pin is asynchronous.
*/
module vof_video_output_format_ctrl
  import vof_pkg::*;
#(
  parameter int ROWS = 256,
  parameter int COLS = 256,
  parameter int RW = $clog2(ROWS),
  parameter int CW = $clog2(COLS)
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // serial control bus register port
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // output enable pin, active low, asynchronous
  input wire logic oe_n_in,
  // video timing generator
  input wire logic field_start_in,
  input wire logic frame_strobe_in,
  input wire logic line_strobe_in,
  input wire logic sav_in,
  input wire logic eav_in,
  input wire logic [RW-1:0] row_idx_in,
  input wire logic [CW-1:0] col_idx_in,
  // clock generator
  input wire logic qck_src_in,
  input wire logic [1:0] strobe_clock_mode_field_in,
  // converter pixel stream
  input wire logic pix_valid_in,
  input wire logic [7:0] pix_data_in,
  output logic pix_ready_out,
  // array addressing and clock generator tick
  output logic [RW-1:0] row_addr_out,
  output logic [CW-1:0] col_addr_out,
  output logic clkgen_tick_out,
  // pads
  output vof_pins_t pins_out
);

  localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);
  localparam logic [RW-1:0] ROW_HALF = RW'((ROWS + 1) / 2);
  localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);

  // reverse an index against the last address
  function automatic logic [RW-1:0] rev_row(input logic [RW-1:0] r);
    rev_row = ROW_LAST - r;
  endfunction

  function automatic logic [CW-1:0] rev_col(input logic [CW-1:0] c);
    rev_col = COL_LAST - c;
  endfunction

  logic [7:0] readout_reg;
  logic [7:0] outbus_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic oe_n_meta_reg;
  logic oe_n_sync_reg;
  logic strb_dis_eff_reg;
  logic qck_dis_eff_reg;
  logic data_dis_eff_reg;
  logic [1:0] prediv_cnt_reg;
  logic [1:0] prediv_cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [RW-1:0] row_addr_reg;
  logic [RW-1:0] row_addr_next;
  logic [CW-1:0] col_addr_reg;
  logic [CW-1:0] col_addr_next;
  vof_ser_t st_reg;
  vof_ser_t st_next;
  logic [7:0] byte_reg;
  logic [7:0] byte_next;
  logic code_pend_reg;
  logic code_pend_next;
  logic [7:0] code_val_reg;
  logic [7:0] code_val_next;
  logic ready_reg;
  logic ready_next;
  vof_pins_t pins_reg;
  vof_pins_t pins_next;

  // register decode
  wire logic wr_readout = reg_wr_in && (reg_addr_in == ADDR_READOUT);
  wire logic wr_outbus = reg_wr_in && (reg_addr_in == ADDR_OUTBUS);

  // read data straight from the registers, not the retimed copies
  assign rdata_next = (reg_addr_in == ADDR_READOUT) ? readout_reg :
                      (reg_addr_in == ADDR_OUTBUS) ? outbus_reg :
                      8'h00; // RULE_06

  // control fields
  wire logic eight_wire = outbus_reg[OB_WIDTH_HI]; // RULE_10
  wire logic five_wire = (outbus_reg[1:0] == WIDTH_FIVE); // RULE_10
  wire logic codes_on = !outbus_reg[OB_CODE_OFF]; // RULE_12
  wire logic retime_on = outbus_reg[OB_RETIME];
  wire logic qck_free =
    (strobe_clock_mode_field_in == QCK_FREE); // RULE_18

  // tri-state bits reach the pads directly or at the field start
  wire logic dis_update = !retime_on || field_start_in; // RULE_14 RULE_19

  // predivider: ticks on counts 0 and 1, idle on 2
  assign prediv_cnt_next =
    (readout_reg[RO_PREDIV] && (prediv_cnt_reg != PREDIV_LAST)) ?
    prediv_cnt_reg + 2'h1 : 2'h0;
  assign tick_next = !readout_reg[RO_PREDIV] ||
                     (prediv_cnt_reg != PREDIV_LAST); // RULE_07

  // row order: shuffle puts even rows first, then optional flip
  wire logic [RW-1:0] row_odd_base = row_idx_in - ROW_HALF;
  wire logic [RW-1:0] row_shuf = (row_idx_in < ROW_HALF) ?
    (row_idx_in << 1) : ((row_odd_base << 1) | RW'(1)); // RULE_01
  wire logic [RW-1:0] row_pre =
    readout_reg[RO_VSHUF] ? row_shuf : row_idx_in;
  assign row_addr_next =
    readout_reg[RO_VFLIP] ? rev_row(row_pre) : row_pre; // RULE_03

  // column order: mirror starts from the rightmost column
  assign col_addr_next = readout_reg[RO_HMIRR] ?
    rev_col(col_idx_in) : col_idx_in; // RULE_02

  // serialiser handshake; a pending code outranks a pixel
  wire logic can_load = (st_reg != SER_HI);
  wire logic take_code = can_load && code_pend_reg;
  wire logic take_pix = pix_valid_in && ready_reg;
  wire logic load = take_code || take_pix;
  wire logic code_req = codes_on && (sav_in || eav_in); // RULE_12

  // code request is held until a byte slot is free; set wins
  assign code_pend_next = code_req || (code_pend_reg && !take_code);
  assign code_val_next = !code_req ? code_val_reg :
                         eav_in ? EAV_CODE : SAV_CODE;
  assign byte_next = take_code ? code_val_reg :
                     take_pix ? pix_data_in : byte_reg;

  // next serialiser state
  always_comb begin
    st_next = SER_IDLE;
    unique case (st_reg)
      SER_HI: st_next = SER_LO;
      SER_IDLE, SER_LO, SER_BYTE: begin
        if (load) begin
          st_next = eight_wire ? SER_BYTE : SER_HI; // RULE_10
        end
      end
    endcase
  end

  assign ready_next = (st_next != SER_HI) && !code_pend_next;

  // data bus contents for each width
  wire logic [3:0] nibble =
    (st_reg == SER_HI) ? byte_reg[7:4] : byte_reg[3:0];
  wire logic narrow_act = (st_reg == SER_HI) || (st_reg == SER_LO);
  wire logic byte_act = (st_reg == SER_BYTE);
  wire logic [7:0] shown_byte = byte_act ? byte_reg : 8'h00;
  wire logic [7:0] data_val = eight_wire ? shown_byte :
    narrow_act ? {3'h0, five_wire && (st_reg == SER_HI), nibble} :
    8'h00; // RULE_10

  // composite disables with the synchronised pin
  wire logic data_dis = oe_n_sync_reg || data_dis_eff_reg; // RULE_13
  wire logic strb_dis = oe_n_sync_reg ||
    (eight_wire ? data_dis_eff_reg : strb_dis_eff_reg); // RULE_08
  wire logic qck_dis = oe_n_sync_reg || qck_dis_eff_reg; // RULE_09

  // pad values
  assign pins_next.data = data_val;
  assign pins_next.data_oe = !data_dis; // RULE_13
  assign pins_next.frame_strobe = eight_wire ? shown_byte[5] :
    (frame_strobe_in && codes_on); // RULE_11 RULE_15
  assign pins_next.frame_strobe_oe = !strb_dis; // RULE_04
  assign pins_next.line_strobe = eight_wire ? shown_byte[6] :
    line_strobe_in; // RULE_11
  assign pins_next.line_strobe_oe = !strb_dis; // RULE_04
  assign pins_next.qualifying_clock =
    qck_src_in && (codes_on || qck_free); // RULE_16
  assign pins_next.qualifying_clock_oe = !qck_dis; // RULE_05

  // software registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      readout_reg <= RST_READOUT;
      outbus_reg <= RST_OUTBUS; // RULE_17
    end else begin
      if (wr_readout) begin
        readout_reg <= reg_wdata_in;
      end
      if (wr_outbus) begin
        outbus_reg <= reg_wdata_in;
      end
    end
  end

  // output enable pin synchroniser, reset to driving
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      oe_n_meta_reg <= 1'b0;
      oe_n_sync_reg <= 1'b0;
    end else begin
      oe_n_meta_reg <= oe_n_in;
      oe_n_sync_reg <= oe_n_meta_reg;
    end
  end

  // effective tri-state bits, direct or retimed
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      strb_dis_eff_reg <= 1'b0;
      qck_dis_eff_reg <= 1'b0;
      data_dis_eff_reg <= 1'b0;
    end else if (dis_update) begin
      strb_dis_eff_reg <= readout_reg[RO_STRB_DIS]; // RULE_04 RULE_14
      qck_dis_eff_reg <= readout_reg[RO_QCK_DIS]; // RULE_05 RULE_14
      data_dis_eff_reg <= outbus_reg[OB_DATA_DIS]; // RULE_13 RULE_14
    end
  end

  // predivider and address mapping
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      prediv_cnt_reg <= 2'h0;
      tick_reg <= 1'b1;
      row_addr_reg <= '0;
      col_addr_reg <= '0;
    end else begin
      prediv_cnt_reg <= prediv_cnt_next;
      tick_reg <= tick_next;
      row_addr_reg <= row_addr_next;
      col_addr_reg <= col_addr_next;
    end
  end

  // serialiser and code insertion
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_reg <= SER_IDLE;
      byte_reg <= 8'h00;
      code_pend_reg <= 1'b0;
      code_val_reg <= 8'h00;
      ready_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      byte_reg <= byte_next;
      code_pend_reg <= code_pend_next;
      code_val_reg <= code_val_next;
      ready_reg <= ready_next;
    end
  end

  // pad register and read data
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pins_reg <= '0;
      pins_reg.data_oe <= 1'b1;
      pins_reg.frame_strobe_oe <= 1'b1;
      pins_reg.line_strobe_oe <= 1'b1;
      pins_reg.qualifying_clock_oe <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      pins_reg <= pins_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_reg;
  assign pix_ready_out = ready_reg;
  assign row_addr_out = row_addr_reg;
  assign col_addr_out = col_addr_reg;
  assign clkgen_tick_out = tick_reg;
  assign pins_out = pins_reg;

endmodule

/* test/vof_props.sv */
/*
  port checks on the video output format block.
  assumes: bound into vof_video_output_format_ctrl, one clock.
*/
module vof_props
  import vof_pkg::*;
(
  // clock, reset, register port
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // pin controls and pads
  input wire logic oe_n_in,
  input wire logic field_start_in,
  input wire logic clkgen_tick_out,
  input wire vof_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ro_reg;
  logic [7:0] ob_reg;
  logic t;
  vof_pins_t p;
  assign p = pins_out;
  assign t = clkgen_tick_out;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  // shadow copies of both registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ro_reg <= RST_READOUT;
      ob_reg <= RST_OUTBUS;
    end else if (reg_wr_in && reg_addr_in == ADDR_READOUT) begin
      ro_reg <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == ADDR_OUTBUS) begin
      ob_reg <= reg_wdata_in;
    end
  end
  AST_OFF: assert property (
    oe_n_in [*3] |=> !p.data_oe && !p.qualifying_clock_oe
    && !p.line_strobe_oe && !p.frame_strobe_oe) else $error("pads driven");
  AST_ON: assert property (
    (!oe_n_in && ob_reg[6:5] == 2'h0) [*3] |=> p.data_oe)
    else $error("data bus off");
  AST_SDIS: assert property (
    (ro_reg[5] && ob_reg[6] == 1'h0 && ob_reg[1] == 1'h0) [*3]
    |=> !p.frame_strobe_oe) else $error("strobe on");
  AST_QDIS: assert property (
    (ro_reg[6] && !ob_reg[6]) [*3] |=> !p.qualifying_clock_oe)
    else $error("qclk on");
  AST_HOLD: assert property (
    (ob_reg[6] && !field_start_in && !oe_n_in) [*4]
    |=> $stable(p.data_oe)) else $error("mid-field update");
  AST_RD: assert property (
    $past(reg_wr_in) && $past(reg_addr_in) == ADDR_OUTBUS
    && reg_addr_in == ADDR_OUTBUS
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("stale read");
  AST_DIV: assert property (
    ro_reg[7] [*5] |-> (t || $past(t))
    && !(t && $past(t) && $past(t, 2))) else $error("bad tick");
  AST_FST: assert property (
    (ob_reg[2] && !ob_reg[1]) [*3] |=> !p.frame_strobe)
    else $error("frame strobe on");
endmodule

bind vof_video_output_format_ctrl vof_props u_vof_props (.clk_sys_in,
  .srst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .oe_n_in, .field_start_in, .clkgen_tick_out, .pins_out);

/* test/vof_rx_model.sv */
/*
  coprocessor side: rebuilds bytes from the pads.
  assumes: five-wire marks the high nibble on bit 4, idle bytes are 0.
*/
module vof_rx_model
  import vof_pkg::*;
(
  // clock, pads, bus width
  input wire logic clk_sys_in,
  input wire vof_pins_t pins_in,
  input wire logic eight_in,
  // rebuilt bytes
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_reg;
  logic [7:0] w;
  logic [3:0] hi_reg;
  logic hi_seen_reg;
  // a released bus shows the inverse of its last level
  assign w = pins_in.data_oe ? pins_in.data : ~last_reg;
  always @(posedge clk_sys_in) begin
    last_reg <= w;
    rx_valid_out <= 1'h0;
    hi_seen_reg <= 1'h0;
    if (eight_in) begin
      rx_valid_out <= pins_in.data_oe && w != 8'h00;
      rx_byte_out <= {w[7], pins_in.line_strobe, pins_in.frame_strobe,
        w[4:0]};
    end else if (hi_seen_reg) begin
      rx_valid_out <= 1'h1;
      rx_byte_out <= {hi_reg, w[3:0]};
    end else begin
      hi_seen_reg <= pins_in.data_oe && w[4];
      hi_reg <= w[3:0];
    end
  end
endmodule

/* test/video_output_format_ctrl_tb.sv */
/*
  self-checking bench of the video output format block.
  assumes: vof_rx_model rebuilds the bytes; eight rows, eight columns.
*/
module video_output_format_ctrl_tb
  import vof_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // design inputs, all set at time zero
  logic clk_sys_in = 1'h0;
  logic srst_in = 1'h1;
  logic reg_wr_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic oe_n_in = 1'h0, field_start_in = 1'h0, frame_strobe_in = 1'h0;
  logic line_strobe_in = 1'h0, sav_in = 1'h0, eav_in = 1'h0;
  logic qck_src_in = 1'h0, pix_valid_in = 1'h0, eight = 1'h0;
  logic [2:0] row_idx_in = 3'h0, col_idx_in = 3'h0;
  logic [1:0] strobe_clock_mode_field_in = 2'h0;
  logic [7:0] pix_data_in = 8'h00;
  // outputs and bench state
  logic [7:0] reg_rdata_out, rx_byte;
  logic pix_ready_out, clkgen_tick_out, rx_valid;
  logic [2:0] row_addr_out, col_addr_out;
  vof_pins_t pins_out;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h32b;
  int error_cnt = 0;
  int samples_checked = 0;
  vof_video_output_format_ctrl #(.ROWS(8), .COLS(8))
    u_vof_video_output_format_ctrl (.clk_sys_in, .srst_in, .reg_wr_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .oe_n_in,
    .field_start_in, .frame_strobe_in, .line_strobe_in, .sav_in, .eav_in,
    .row_idx_in, .col_idx_in, .qck_src_in, .strobe_clock_mode_field_in,
    .pix_valid_in, .pix_data_in, .pix_ready_out, .row_addr_out,
    .col_addr_out, .clkgen_tick_out, .pins_out);
  vof_rx_model u_vof_rx_model (.clk_sys_in, .pins_in(pins_out),
    .eight_in(eight), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] pads();
    return {pins_out.data_oe, pins_out.frame_strobe_oe,
      pins_out.line_strobe_oe, pins_out.qualifying_clock_oe, 1'h0,
      pins_out.frame_strobe, pins_out.line_strobe,
      pins_out.qualifying_clock};
  endfunction
  task automatic nx(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // register cycles, entered and left at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = 1'h1;
    reg_addr_in = a;
    reg_wdata_in = d;
    nx(1);
    reg_wr_in = 1'h0;
    nx(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    nx(2);
    chk(reg_rdata_out, e);
  endtask
  // pixels with bounded waits on ready, each noted as expected
  task automatic burst(input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      pix_valid_in = 1'h1;
      pix_data_in = rnd() | 8'h01;
      exp_q.push_back(pix_data_in);
      for (w = 0; pix_ready_out !== 1'h1 && w < 20; w++) nx(1);
      if (w == 20) error_cnt++;
      if (w == 20) end_sim();
      nx(1);
    end
    pix_valid_in = 1'h0;
    for (w = 0; exp_q.size() > 0 && w < 40; w++) nx(1);
    if (exp_q.size() > 0) error_cnt++;
    if (exp_q.size() > 0) end_sim();
  endtask
  // compare each rebuilt byte with the oldest note
  always @(negedge clk_sys_in) begin
    if (rx_valid === 1'h1 && exp_q.size() > 0) begin
      chk(rx_byte, exp_q.pop_front());
    end else if (rx_valid === 1'h1) begin
      chk(8'h00, 8'hff);
    end
  end
  initial begin
    logic [7:0] v;
    int n;
    int s;
    nx(10);
    srst_in = 1'h0;
    rd(ADDR_READOUT, RST_READOUT);
    rd(ADDR_OUTBUS, RST_OUTBUS);
    rd(8'h20, 8'h00);
    chk(pads() & 8'hf0, 8'hf0);
    v = rnd();
    wr(ADDR_READOUT, v);
    rd(ADDR_READOUT, v);
    // every shuffle, mirror and flip combination over all rows
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_READOUT, 8'(m * 4 + 1));
      for (int r = 0; r < 8; r++) begin
        row_idx_in = 3'(r);
        col_idx_in = 3'(r);
        nx(1);
        s = m[0] ? (r < 4 ? 2 * r : 2 * r - 7) : r;
        chk({5'h0, row_addr_out}, 8'(m[2] ? 7 - s : s));
        chk({5'h0, col_addr_out}, 8'(m[1] ? 7 - r : r));
      end
    end
    // start code ahead of pixels, then eight wires with codes still on
    sav_in = 1'h1;
    exp_q.push_back(SAV_CODE);
    nx(1);
    sav_in = 1'h0;
    burst(4);
    wr(ADDR_OUTBUS, 8'h1a);
    eight = 1'h1;
    burst(6);
    // four wires: high nibble then low nibble, no marker bit
    wr(ADDR_OUTBUS, 8'h19);
    eight = 1'h0;
    v = rnd();
    pix_valid_in = 1'h1;
    pix_data_in = v;
    nx(1);
    pix_valid_in = 1'h0;
    chk({7'h0, pix_ready_out}, 8'h00);
    nx(1);
    chk(pins_out.data, {4'h0, v[7:4]});
    nx(1);
    chk(pins_out.data, {4'h0, v[3:0]});
    wr(ADDR_OUTBUS, 8'h1c);
    eight = 1'h0;
    eav_in = 1'h1;
    nx(1);
    eav_in = 1'h0;
    burst(4);
    // strobes and qualifying clock with codes off, then on
    frame_strobe_in = 1'h1;
    line_strobe_in = 1'h1;
    qck_src_in = 1'h1;
    nx(3);
    chk(pads(), 8'hf2);
    strobe_clock_mode_field_in = QCK_FREE;
    nx(2);
    chk(pads(), 8'hf3);
    wr(ADDR_OUTBUS, RST_OUTBUS);
    strobe_clock_mode_field_in = 2'h0;
    nx(2);
    chk(pads(), 8'hf7);
    wr(ADDR_READOUT, 8'h81);
    nx(3);
    n = 0;
    repeat (6) begin
      nx(1);
      n += clkgen_tick_out;
    end
    chk(8'(n), 8'h04);
    // output enable pin, disable bits, field retiming
    oe_n_in = 1'h1;
    nx(4);
    chk(pads() & 8'hf0, 8'h00);
    oe_n_in = 1'h0;
    wr(ADDR_READOUT, 8'h61);
    nx(3);
    chk(pads() & 8'hf0, 8'h80);
    wr(ADDR_READOUT, 8'h01);
    wr(ADDR_OUTBUS, 8'h78);
    rd(ADDR_OUTBUS, 8'h78);
    chk(pads() & 8'hf0, 8'hf0);
    field_start_in = 1'h1;
    nx(1);
    field_start_in = 1'h0;
    nx(1);
    chk(pads() & 8'hf0, 8'h70);
    // mid-run reset brings every pad back to driving
    srst_in = 1'h1;
    nx(2);
    srst_in = 1'h0;
    chk(pads() & 8'hf0, 8'hf0);
    rd(ADDR_OUTBUS, RST_OUTBUS);
    end_sim();
  end
endmodule
